// ===== hdl/csw_pkg.sv
/*
  Constants for the CPU clock source switch: register addresses, bit
  positions, reset values, divider codes and source indices.
  Assumes an 8-bit register port with a 3-bit word address.
*/
package csw_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [2:0] CSW_ADDR_OSC_CTL   = 3'h0;
  localparam logic [2:0] CSW_ADDR_MAIN_OSC  = 3'h1;
  localparam logic [2:0] CSW_ADDR_MAIN_MODE = 3'h2;
  localparam logic [2:0] CSW_ADDR_PROC_CLK  = 3'h3;
  localparam logic [2:0] CSW_ADDR_INT_OSC   = 3'h4;

  // ----------------------------------------------------------------
  // Bit positions
  // ----------------------------------------------------------------
  localparam int CSW_BIT_EXT_SEL     = 0;
  localparam int CSW_BIT_PIN_SEL     = 1;
  localparam int CSW_BIT_SUB_SEL     = 2;
  localparam int CSW_BIT_HS_STOP     = 0;
  localparam int CSW_BIT_MAIN_SRC    = 0;
  localparam int CSW_BIT_MAIN_STATUS = 1;
  localparam int CSW_BIT_HS_MAIN_SEL = 2;
  localparam int CSW_BIT_DIV_LSB     = 0;
  localparam int CSW_BIT_CPU_SRC     = 4;
  localparam int CSW_BIT_CPU_STATUS  = 5;
  localparam int CSW_BIT_INT_STOP    = 0;

  // ----------------------------------------------------------------
  // Reset values and divider codes
  // ----------------------------------------------------------------
  localparam logic       CSW_RST_HS_STOP  = 1'b1;
  localparam logic       CSW_RST_INT_STOP = 1'b0;
  localparam logic [2:0] CSW_DIV_RST      = 3'h1;
  localparam logic [2:0] CSW_DIV_MAX      = 3'h4;

  // ----------------------------------------------------------------
  // Source indices in the synchroniser vector
  // ----------------------------------------------------------------
  localparam int CSW_SRC_X1  = 0;
  localparam int CSW_SRC_EXT = 1;
  localparam int CSW_SRC_INT = 2;
  localparam int CSW_SRC_SUB = 3;
  localparam int CSW_SRC_NUM = 4;

endpackage

// ===== hdl/csw_src_if.sv
/*
  Carrier between the switch and its input synchroniser bank.
  Assumes both ends run on ref_clk.
*/
`timescale 1ns/100ps
interface csw_src_if #(parameter int W = 4);
  logic [W-1:0] raw;
  logic [W-1:0] sync;
  modport sync_side (input raw, output sync);
  modport user_side (output raw, input sync);
endinterface

// ===== hdl/csw_sync.sv
/*
  Two-stage synchroniser bank for the clock source pins.
  Assumes the raw levels are asynchronous to ref_clk.
*/
`timescale 1ns/100ps
module csw_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Source levels
  csw_src_if.sync_side src
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } csw_sync_t;

  csw_sync_t st;
  csw_sync_t next_st;

  if (W < 1) begin : g_chk
    $error("csw_sync: W must be at least 1");
  end

  always_comb begin
    next_st        = st;
    next_st.meta   = src.raw;
    next_st.stable = st.meta;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign src.sync = st.stable;

endmodule

// ===== hdl/csw_switch.sv
/*
  CPU clock source switch: register port, source gating, main clock
  selection, CPU clock divider and glitch-free switching.
  Assumes source clocks are much slower than ref_clk and arrive
  asynchronously; outputs are ref_clk-registered clock levels.
*/
// The address map and the strobed register port were decided locally.
`timescale 1ns/100ps
module csw_switch
  import csw_pkg::*;
#(
  parameter int ADDR_W = 3
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // Register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output      logic [7:0]        rd_data,
  // Source clock pins
  input  wire logic              x1_clk,
  input  wire logic              ext_clk,
  input  wire logic              int_clk,
  input  wire logic              sub_clk,
  // Source and pin control
  output      logic              x1_port_mode,
  output      logic              x2_port_mode,
  output      logic              x2_ext_input_mode,
  output      logic              hs_osc_enable,
  output      logic              ext_input_enable,
  output      logic              int_osc_enable,
  output      logic              sub_osc_enable,
  // Clock outputs
  output      logic              periph_clk,
  output      logic              cpu_clk,
  output      logic              main_clock_status
);

  typedef struct packed {
    logic       ext_sel;
    logic       pin_sel;
    logic       sub_sel;
    logic       hs_stop;
    logic       int_stop;
    logic       hs_main_sel;
    logic       main_src;
    logic       main_status;
    logic       cpu_src_req;
    logic       cpu_src_cur;
    logic [2:0] div_req;
    logic [2:0] div_cur;
    logic [3:0] cnt;
    logic       prev_cpu;
    logic       periph_clk;
    logic       cpu_clk;
    logic [7:0] rd_data;
  } csw_state_t;

  csw_state_t st;
  csw_state_t next_st;

  if (ADDR_W < 3) begin : g_chk
    $error("csw_switch: ADDR_W must be at least 3");
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  csw_src_if #(.W(CSW_SRC_NUM)) src ();

  assign src.raw = {sub_clk, int_clk, ext_clk, x1_clk};

  csw_sync #(.W(CSW_SRC_NUM)) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .src     (src.sync_side)
  );

  // ----------------------------------------------------------------
  // Source levels
  // ----------------------------------------------------------------
  logic       hs_lvl;
  logic       int_lvl;
  logic       sub_lvl;
  logic       main_lvl;
  logic       main_tgt_lvl;
  logic       main_req;
  logic       cpu_lvl;
  logic       cpu_edge;
  logic       cpu_tgt_lvl;
  logic [4:0] span;
  logic [3:0] last;
  logic       wr_hit;

  always_comb begin
    hs_lvl = 1'b0;
    if (!st.hs_stop && st.pin_sel) begin
      hs_lvl = st.ext_sel ? src.sync[CSW_SRC_EXT]
                          : src.sync[CSW_SRC_X1];
    end
    int_lvl      = src.sync[CSW_SRC_INT] & ~st.int_stop;
    sub_lvl      = src.sync[CSW_SRC_SUB] & st.sub_sel;
    main_req     = st.hs_main_sel & st.main_src;
    main_lvl     = st.main_status ? hs_lvl : int_lvl;
    main_tgt_lvl = main_req ? hs_lvl : int_lvl;
    cpu_lvl      = st.cpu_src_cur ? sub_lvl : main_lvl;
    cpu_edge     = cpu_lvl ^ st.prev_cpu;
    cpu_tgt_lvl  = st.cpu_src_req ? sub_lvl : main_lvl;
    span         = 5'h1 << st.div_cur;
    last         = 4'(span - 5'h1);
    wr_hit       = wr_en && ((addr >> 3) == '0);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st          = st;
    next_st.prev_cpu = cpu_lvl;

    // Register writes
    if (wr_hit) begin
      unique case (addr[2:0])
        CSW_ADDR_OSC_CTL: begin
          next_st.ext_sel = wr_data[CSW_BIT_EXT_SEL];
          next_st.pin_sel = wr_data[CSW_BIT_PIN_SEL];
          next_st.sub_sel = wr_data[CSW_BIT_SUB_SEL];
        end
        CSW_ADDR_MAIN_OSC: begin
          // Stopping the high-speed source is refused while it runs CPU
          if (!(wr_data[CSW_BIT_HS_STOP] && st.main_status &&
                !st.cpu_src_cur)) begin
            next_st.hs_stop = wr_data[CSW_BIT_HS_STOP];
          end
        end
        CSW_ADDR_MAIN_MODE: begin
          next_st.main_src = wr_data[CSW_BIT_MAIN_SRC];
          // High-speed select sticks while high-speed is main
          next_st.hs_main_sel = wr_data[CSW_BIT_HS_MAIN_SEL] |
                                st.main_status;
        end
        CSW_ADDR_PROC_CLK: begin
          next_st.cpu_src_req = wr_data[CSW_BIT_CPU_SRC];
          if (wr_data[CSW_BIT_DIV_LSB +: 3] <= CSW_DIV_MAX) begin
            next_st.div_req = wr_data[CSW_BIT_DIV_LSB +: 3];
          end
        end
        CSW_ADDR_INT_OSC: begin
          // Internal oscillator may stop only when CPU is elsewhere
          if (!(wr_data[CSW_BIT_INT_STOP] && !st.main_status &&
                !st.cpu_src_cur)) begin
            next_st.int_stop = wr_data[CSW_BIT_INT_STOP];
          end
        end
        default: begin
        end
      endcase
    end

    // Main clock switch only while old and new sources are both low
    if ((main_req != st.main_status) && !main_lvl &&
        !main_tgt_lvl) begin
      next_st.main_status = main_req;
    end
    next_st.periph_clk = main_lvl;

    // CPU clock divider
    if (cpu_edge) begin
      if (st.cnt == last) begin
        next_st.cnt     = 4'h0;
        next_st.cpu_clk = ~st.cpu_clk;
      end else begin
        next_st.cnt = st.cnt + 4'h1;
      end
    end

    // Take new CPU source and ratio only at a low, idle point
    if (((st.cpu_src_req != st.cpu_src_cur) ||
         (st.div_req != st.div_cur)) &&
        !st.cpu_clk && !cpu_edge && (st.cnt == 4'h0) &&
        !cpu_tgt_lvl) begin
      next_st.cpu_src_cur = st.cpu_src_req;
      next_st.div_cur     = st.div_req;
      next_st.prev_cpu    = cpu_tgt_lvl;
    end

    // Register reads
    next_st.rd_data = 8'h00;
    if (rd_en && ((addr >> 3) == '0)) begin
      unique case (addr[2:0])
        CSW_ADDR_OSC_CTL: begin
          next_st.rd_data[CSW_BIT_EXT_SEL] = st.ext_sel;
          next_st.rd_data[CSW_BIT_PIN_SEL] = st.pin_sel;
          next_st.rd_data[CSW_BIT_SUB_SEL] = st.sub_sel;
        end
        CSW_ADDR_MAIN_OSC: begin
          next_st.rd_data[CSW_BIT_HS_STOP] = st.hs_stop;
        end
        CSW_ADDR_MAIN_MODE: begin
          next_st.rd_data[CSW_BIT_MAIN_SRC]    = st.main_src;
          next_st.rd_data[CSW_BIT_MAIN_STATUS] = st.main_status;
          next_st.rd_data[CSW_BIT_HS_MAIN_SEL] = st.hs_main_sel;
        end
        CSW_ADDR_PROC_CLK: begin
          next_st.rd_data[CSW_BIT_DIV_LSB +: 3] = st.div_req;
          next_st.rd_data[CSW_BIT_CPU_SRC]      = st.cpu_src_req;
          next_st.rd_data[CSW_BIT_CPU_STATUS]   = st.cpu_src_cur;
        end
        CSW_ADDR_INT_OSC: begin
          next_st.rd_data[CSW_BIT_INT_STOP] = st.int_stop;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st          <= '0;
      st.hs_stop  <= CSW_RST_HS_STOP;
      st.int_stop <= CSW_RST_INT_STOP;
      st.div_req  <= CSW_DIV_RST;
      st.div_cur  <= CSW_DIV_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign x1_port_mode      = ~st.pin_sel | st.ext_sel;
  assign x2_port_mode      = ~st.pin_sel;
  assign x2_ext_input_mode = st.pin_sel & st.ext_sel;
  assign hs_osc_enable     = st.pin_sel & ~st.ext_sel & ~st.hs_stop;
  assign ext_input_enable  = st.pin_sel & st.ext_sel & ~st.hs_stop;
  assign int_osc_enable    = ~st.int_stop;
  assign sub_osc_enable    = st.sub_sel;
  assign periph_clk        = st.periph_clk;
  assign cpu_clk           = st.cpu_clk;
  assign main_clock_status = st.main_status;
  assign rd_data           = st.rd_data;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_main_req_safe;
    main_req && !st.main_status && !main_lvl && !main_tgt_lvl;
  endsequence

  sequence s_cpu_on_hs;
    st.main_status && !st.cpu_src_cur;
  endsequence

  AST_PIN_MODE: assert property (@(posedge ref_clk) disable iff (rst)
    (st.ext_sel && st.pin_sel) |->
      (x1_port_mode && x2_ext_input_mode && !hs_osc_enable))
    else $error("pin mode wrong with both selects set");

  AST_HS_GATED: assert property (@(posedge ref_clk) disable iff (rst)
    st.hs_stop |-> (!hs_osc_enable && !ext_input_enable &&
                    !hs_lvl))
    else $error("high-speed source passes while stopped");

  AST_MAIN_SWITCH: assert property (@(posedge ref_clk) disable iff (rst)
    s_main_req_safe |=> main_clock_status)
    else $error("main clock did not move to high-speed");

  AST_PERIPH_LOCK: assert property (@(posedge ref_clk) disable iff (rst)
    st.main_status |-> st.hs_main_sel)
    else $error("high-speed select lost while high-speed is main");

  AST_CPU_DIV1: assert property (@(posedge ref_clk) disable iff (rst)
    (!st.cpu_src_cur && (st.div_cur == 3'h0) && cpu_edge) |=>
      (cpu_clk == $past(cpu_lvl)))
    else $error("undivided CPU clock does not follow main clock");

  AST_DIV_LEGAL: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_hit && (addr[2:0] == CSW_ADDR_PROC_CLK) &&
     (wr_data[2:0] > CSW_DIV_MAX)) |=> $stable(st.div_req))
    else $error("prohibited divider code accepted");

  AST_INT_STOP: assert property (@(posedge ref_clk) disable iff (rst)
    (s_cpu_on_hs ##0 (wr_hit && (addr[2:0] == CSW_ADDR_INT_OSC) &&
     wr_data[CSW_BIT_INT_STOP])) |=> !int_osc_enable)
    else $error("internal oscillator stop refused on high-speed");

  AST_SUB_STOP: assert property (@(posedge ref_clk) disable iff (rst)
    (st.cpu_src_cur && wr_hit && (addr[2:0] == CSW_ADDR_MAIN_OSC) &&
     wr_data[CSW_BIT_HS_STOP]) |=> st.hs_stop)
    else $error("high-speed stop refused on subsystem clock");

  AST_RESET: assert property (@(posedge ref_clk)
    rst |-> (!cpu_clk && !periph_clk && (st.div_cur == CSW_DIV_RST) &&
             st.hs_stop && !main_clock_status))
    else $error("state not at reset value during reset");

  AST_NO_RUNT: assert property (@(posedge ref_clk) disable iff (rst)
    ($changed(st.div_cur) || $changed(st.cpu_src_cur)) |->
      (!$past(st.cpu_clk) && !cpu_clk))
    else $error("CPU clock selection changed while output high");

endmodule

// ===== sim/csw_switch_test.sv
/*
  Self-checking bench for the CPU clock source switch: register readback,
  pin modes, source gating, main and CPU clock switching, divider ratios.
  Assumes csw_pkg is compiled first and the switch body keeps its notes.
*/
`timescale 1ns/100ps
module csw_switch_test
  import csw_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  typedef struct {
    logic [7:0] wdata;
    int         half;
  } csw_row_t;

  logic       ref_clk = 1'b0;
  logic       rst     = 1'b0;
  logic [2:0] addr    = 3'h0;
  logic [7:0] wr_data = 8'h00;
  logic       wr_en   = 1'b0;
  logic       rd_en   = 1'b0;
  logic [7:0] rd_data;
  logic [3:0] t       = 4'h0;
  logic       x1_clk, ext_clk, int_clk, sub_clk;
  logic       x1_port_mode, x2_port_mode, x2_ext_input_mode;
  logic       hs_osc_enable, ext_input_enable, int_osc_enable;
  logic       sub_osc_enable, periph_clk, cpu_clk, main_clock_status;
  int         n_fail  = 0;
  int         n_tests = 0;
  int         n;
  // Int osc half period 4 cycles: divider codes 0..4, then 5 ignored
  csw_row_t   rows [6] = '{'{8'h00, 4}, '{8'h01, 8}, '{8'h02, 16},
                           '{8'h03, 32}, '{8'h04, 64}, '{8'h05, 64}};

  always #5 ref_clk = ~ref_clk;
  // Source clocks: external 1, crystal 2, internal 4, subsystem 8
  always @(posedge ref_clk) t <= t + 4'h1;
  assign ext_clk = t[0];
  assign x1_clk  = t[1];
  assign int_clk = t[2];
  assign sub_clk = t[3];

  csw_switch csw_switch_i (
    .ref_clk           (ref_clk),
    .rst               (rst),
    .addr              (addr),
    .wr_data           (wr_data),
    .wr_en             (wr_en),
    .rd_en             (rd_en),
    .rd_data           (rd_data),
    .x1_clk            (x1_clk),
    .ext_clk           (ext_clk),
    .int_clk           (int_clk),
    .sub_clk           (sub_clk),
    .x1_port_mode      (x1_port_mode),
    .x2_port_mode      (x2_port_mode),
    .x2_ext_input_mode (x2_ext_input_mode),
    .hs_osc_enable     (hs_osc_enable),
    .ext_input_enable  (ext_input_enable),
    .int_osc_enable    (int_osc_enable),
    .sub_osc_enable    (sub_osc_enable),
    .periph_clk        (periph_clk),
    .cpu_clk           (cpu_clk),
    .main_clock_status (main_clock_status)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  function automatic logic [15:0] outs();
    return {6'h00, cpu_clk, periph_clk, main_clock_status, int_osc_enable,
            hs_osc_enable, ext_input_enable, sub_osc_enable,
            x1_port_mode, x2_port_mode, x2_ext_input_mode};
  endfunction

  function automatic logic [15:0] pins();
    return {11'h000, x1_port_mode, x2_port_mode, x2_ext_input_mode,
            hs_osc_enable, ext_input_enable};
  endfunction

  task automatic conclude();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge ref_clk);
    wr_en   <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    chk("read data", 16'(e), 16'(rd_data));
  endtask

  // Skips two level changes, then counts cycles of the next half period
  task automatic half_period(input bit sel, output int cnt);
    logic s;
    int   seen;
    s    = sel ? periph_clk : cpu_clk;
    seen = 0;
    cnt  = 0;
    for (int k = 0; k < 1000 && seen < 3; k++) begin
      @(posedge ref_clk);
      #1;
      cnt++;
      if ((sel ? periph_clk : cpu_clk) !== s) begin
        s = ~s;
        seen++;
        if (seen < 3)
          cnt = 0;
      end
    end
    if (seen < 3) begin
      n_fail++;
      conclude();
    end
  endtask

  task automatic wait_status(input logic v);
    int k;
    for (k = 0; k < 300 && main_clock_status !== v; k++) begin
      @(posedge ref_clk);
      #1;
    end
    if (k == 300) begin
      n_fail++;
      conclude();
    end
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    // Edge at time zero so the asynchronous reset takes hold at once
    rst <= 1'b1;
    repeat (20) @(posedge ref_clk);
    #1;
    chk("reset outputs", 16'h0046, outs());
    @(posedge ref_clk);
    rst <= 1'b0;
    rd(3'h0, 8'h00);
    rd(3'h1, 8'h01);
    rd(3'h2, 8'h00);
    rd(3'h3, 8'h01);
    rd(3'h4, 8'h00);
    // Internal osc stop refused while it feeds the CPU
    wr(3'h4, 8'h01);
    rd(3'h4, 8'h00);
    chk("int osc on", 16'h0001, 16'(int_osc_enable));
    foreach (rows[i]) begin
      wr(3'h3, rows[i].wdata);
      half_period(1'b0, n);
      chk("cpu half period", 16'(rows[i].half), 16'(n));
    end
    wr(3'h5, 8'hff);
    rd(3'h5, 8'h00);
    rd(3'h0, 8'h00);
    // Pin modes and high-speed gating
    wr(3'h0, 8'h03);
    chk("pins ext stopped", 16'h0014, pins());
    wr(3'h1, 8'h00);
    chk("pins ext run", 16'h0015, pins());
    // External input becomes main clock, then hands back
    wr(3'h2, 8'h05);
    wait_status(1'b1);
    half_period(1'b1, n);
    chk("periph half ext", 16'h0001, 16'(n));
    wr(3'h2, 8'h00);
    wait_status(1'b0);
    wr(3'h1, 8'h01);
    chk("pins ext stop", 16'h0014, pins());
    wr(3'h0, 8'h02);
    chk("pins xtal stopped", 16'h0000, pins());
    wr(3'h1, 8'h00);
    chk("pins xtal run", 16'h0002, pins());
    // Crystal becomes main clock
    wr(3'h3, 8'h01);
    wr(3'h2, 8'h05);
    wait_status(1'b1);
    rd(3'h2, 8'h07);
    half_period(1'b1, n);
    chk("periph half xtal", 16'h0002, 16'(n));
    half_period(1'b0, n);
    chk("cpu half xtal", 16'h0004, 16'(n));
    wr(3'h2, 8'h01);
    rd(3'h2, 8'h07);
    wr(3'h1, 8'h01);
    rd(3'h1, 8'h00);
    wr(3'h4, 8'h01);
    chk("int osc stop", 16'h0000, 16'(int_osc_enable));
    wr(3'h4, 8'h00);
    wr(3'h2, 8'h00);
    wait_status(1'b0);
    half_period(1'b1, n);
    chk("periph half int", 16'h0004, 16'(n));
    // CPU moves to the subsystem clock
    wr(3'h0, 8'h06);
    chk("sub osc on", 16'h0001, 16'(sub_osc_enable));
    wr(3'h3, 8'h11);
    half_period(1'b0, n);
    chk("cpu half sub", 16'h0010, 16'(n));
    rd(3'h3, 8'h31);
    wr(3'h4, 8'h01);
    rd(3'h4, 8'h01);
    wr(3'h1, 8'h01);
    chk("sources stopped", 16'h0000,
        16'({int_osc_enable, hs_osc_enable}));
    half_period(1'b0, n);
    chk("cpu half sub kept", 16'h0010, 16'(n));
    // CPU leaves the subsystem clock for the crystal
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h05);
    wait_status(1'b1);
    wr(3'h3, 8'h01);
    half_period(1'b0, n);
    chk("cpu half back xtal", 16'h0004, 16'(n));
    rd(3'h3, 8'h01);
    // Second reset in mid-run
    @(posedge ref_clk);
    rst <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk("mid reset outputs", 16'h0046, outs());
    @(posedge ref_clk);
    rst <= 1'b0;
    rd(3'h3, 8'h01);
    half_period(1'b0, n);
    chk("cpu half default", 16'h0008, 16'(n));
    conclude();
  end
endmodule
